// ===== verilog/spwm_pkg.sv
// Purpose: Shared constants, field layouts and carriers of the standard PWM channel.
// Assumes: APB byte addresses, one 32-bit word per register, narrow data in low bits.
// Notes:   Timer registers repeat with a fixed stride, one group per period timer.
`default_nettype none

package spwm_pkg;

  localparam int unsigned NUM_TMR = 3;
  localparam int unsigned Q_CYCLES = 4;

  // Register byte addresses.
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_DUTY_HI  = 12'h004;
  localparam logic [11:0] ADDR_DUTY_BUF = 12'h008;
  localparam logic [11:0] ADDR_TSEL     = 12'h00c;
  localparam logic [11:0] ADDR_DIR      = 12'h010;
  localparam logic [11:0] ADDR_FLAG     = 12'h014;
  localparam logic [11:0] ADDR_STAT     = 12'h018;
  localparam logic [11:0] ADDR_TMR_BASE = 12'h020;
  localparam logic [11:0] TMR_STRIDE    = 12'h010;
  localparam logic [11:0] TMR_CON_OFS   = 12'h000;
  localparam logic [11:0] TMR_PER_OFS   = 12'h004;
  localparam logic [11:0] TMR_CNT_OFS   = 12'h008;

  // Field positions.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DLSB_LSB = 4;
  localparam logic [1:0]  CTRL_PWM_MODE = 2'h3;
  localparam int unsigned TCON_PSC_LSB  = 0;
  localparam int unsigned TCON_RUN_BIT  = 2;
  localparam int unsigned TCON_POST_LSB = 3;
  localparam int unsigned STAT_PWM_BIT  = 0;
  localparam int unsigned STAT_OE_BIT   = 1;
  localparam int unsigned STAT_PIN_BIT  = 2;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic       DIR_RST  = 1'b1;
  localparam logic [6:0] TCON_RST = 7'h00;
  localparam logic [7:0] PER_RST  = 8'hff;

  typedef enum logic [1:0] {
    PSC_1   = 2'b00,
    PSC_4   = 2'b01,
    PSC_16  = 2'b10,
    PSC_16B = 2'b11
  } spwm_psc_t;

  typedef struct packed {
    logic       run;
    spwm_psc_t  prescale;
    logic [3:0] postscale;
    logic [7:0] period;
  } spwm_tmr_cfg_t;

  typedef struct packed {
    logic [7:0] count;
    logic [1:0] low2;
    logic       rollover;
    logic       flag_set;
  } spwm_tmr_stat_t;

endpackage : spwm_pkg

`default_nettype wire

// ===== verilog/spwm_timer.sv
// Purpose: One 8-bit period timer with prescaler and postscaler.
// Assumes: q_tick is a one-cycle pulse once per instruction cycle, absent in sleep.
// Notes:   The rollover output is combinational so the reload lands on the reset edge.
`default_nettype none

module spwm_timer
  import spwm_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Instruction cycle timing
  input  wire logic           q_tick,
  input  wire logic [1:0]     q_phase,
  // Configuration and state
  input  wire spwm_tmr_cfg_t  cfg,
  output var spwm_tmr_stat_t  stat
);

  logic [3:0] psc_q;
  logic [7:0] cnt_q;
  logic [3:0] post_q;
  logic       psc_last;
  logic       inc;
  logic       at_limit;

  assign psc_last = (cfg.prescale == PSC_1) ||
                    ((cfg.prescale == PSC_4) && (psc_q[1:0] == 2'h3)) ||
                    (cfg.prescale[1] && (psc_q == 4'hf));
  assign inc      = q_tick && cfg.run && psc_last;
  assign at_limit = (cnt_q == cfg.period);

  assign stat.count    = cnt_q;
  assign stat.low2     = (cfg.prescale == PSC_1) ? q_phase :
                         (cfg.prescale == PSC_4) ? psc_q[1:0] : psc_q[3:2];
  assign stat.rollover = inc && at_limit;
  // The postscaler only paces the match flag, never the period.
  assign stat.flag_set = stat.rollover && (post_q == cfg.postscale);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= 4'h0;
    end else if (q_tick && cfg.run) begin
      psc_q <= psc_last ? 4'h0 : psc_q + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (inc) begin
      cnt_q <= at_limit ? 8'h00 : cnt_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q <= 4'h0;
    end else if (stat.rollover) begin
      post_q <= stat.flag_set ? 4'h0 : post_q + 4'h1;
    end
  end

endmodule // spwm_timer

`default_nettype wire

// ===== verilog/spwm_out.sv
// Purpose: Output latch of the PWM channel: set at the period start, cleared on match.
// Assumes: reload is a one-cycle pulse on the edge where the selected timer resets.
// Notes:   A duty value beyond the period never matches, so the level simply holds.
`default_nettype none

module spwm_out (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Channel state
  input  wire logic       pwm_mode,
  input  wire logic       advance,
  input  wire logic       reload,
  input  wire logic [9:0] duty_next,
  input  wire logic [9:0] duty_lat,
  input  wire logic [9:0] timebase,
  // Output level
  output logic            pwm_q
);

  logic matched;
  logic set_q;

  assign matched = (timebase == duty_lat);

  // The set lags the reload by one clock, as the clear lags the match, so the
  // high time is exactly the duty value in time base steps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_q <= 1'b0;
      pwm_q <= 1'b0;
    end else if (!pwm_mode) begin
      set_q <= 1'b0;
      pwm_q <= 1'b0;
    end else if (advance) begin
      set_q <= reload && (duty_next != 10'h000);
      if (set_q) begin
        pwm_q <= 1'b1;
      end else if (matched) begin
        pwm_q <= 1'b0;
      end
    end
  end

endmodule // spwm_out

`default_nettype wire

// ===== verilog/spwm_top.sv
// Purpose: Standard PWM channel with three selectable period timers behind APB.
// Assumes: sleep_en comes from logic on pclk; pin_i comes from the pad.
// Notes:   The slave answers with no wait states; read data is captured in setup.
//
// What this block does
// - Period is (period limit plus one) times four clocks times prescale.
// - After count equals limit, next increment clears timer and latches duty.
// - Pin goes high at period start unless programmed duty is zero.
// - Duty is ten bits: high byte register plus control bits five to four.
// - Duty writes are taken anytime but only act after next reload.
// - In PWM mode the duty buffer ignores writes and reads latched value.
// - Buffer byte and hidden two-bit latch load together for glitch-free output.
// - Time base is count plus clock phase at 1:1, else prescaler bits.
// - When time base equals latched duty the pin drops for the period.
// - Duty beyond the period leaves the pin at its level.
// - Timer postscaler never changes the output period.
// - Two-bit timer select picks which of three timers drives the channel.
// - Resolution is log2 of four times (limit plus one) bits.
// - High time is duty times clock period times prescale.
// - Duty ratio is duty over four times (limit plus one).
// - In sleep the timers and channel freeze and resume where they stopped.
// - The PWM only reaches the pin while its direction bit is cleared.
// - Writing zero to the channel control register releases the pin.
// - Reset restores all registers and turns the pin into an input.
//
// Implementation choices: the address map and register access over APB.
`default_nettype none

module spwm_top
  import spwm_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power state
  input  wire logic        sleep_en,
  // Output pin
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe
);

  // Registers.
  logic [7:0]     channel_control_reg_q;
  logic [7:0]     duty_high_bits_reg_q;
  logic [7:0]     duty_buffer_reg_q;
  logic [1:0]     duty_lsb_latch_q;
  logic [1:0]     timer_select_reg_q;
  logic           pin_direction_bit_q;
  logic [2:0]     timer_match_flag_q;
  logic [6:0]     timer_control_reg_q [NUM_TMR];
  logic [7:0]     period_limit_reg_q  [NUM_TMR];
  logic [1:0]     q_phase_q;
  logic           pin_meta_q;
  logic           pin_sync_q;
  logic [31:0]    prdata_q;

  // Decode and datapath wires.
  logic           setup;
  logic           wr;
  logic           hit_ctrl;
  logic           hit_duty_hi;
  logic           hit_duty_buf;
  logic           hit_tsel;
  logic           hit_dir;
  logic           hit_flag;
  logic           hit_stat;
  logic [2:0]     hit_tcon;
  logic [2:0]     hit_per;
  logic [2:0]     hit_cnt;
  logic           mapped;
  logic           q_tick;
  logic           pwm_mode;
  logic           sel_valid;
  logic           reload;
  logic [9:0]     timebase;
  logic [9:0]     duty_prog;
  logic [9:0]     duty_lat;
  logic           pwm_level;
  logic [31:0]    rd_data;
  logic [2:0]     flag_set;
  spwm_tmr_cfg_t  tmr_cfg  [NUM_TMR];
  spwm_tmr_stat_t tmr_stat [NUM_TMR];

  // Bus decode.
  assign setup        = psel && !penable;
  assign wr           = psel && penable && pwrite;
  assign hit_ctrl     = (paddr == ADDR_CTRL);
  assign hit_duty_hi  = (paddr == ADDR_DUTY_HI);
  assign hit_duty_buf = (paddr == ADDR_DUTY_BUF);
  assign hit_tsel     = (paddr == ADDR_TSEL);
  assign hit_dir      = (paddr == ADDR_DIR);
  assign hit_flag     = (paddr == ADDR_FLAG);
  assign hit_stat     = (paddr == ADDR_STAT);
  assign mapped       = hit_ctrl || hit_duty_hi || hit_duty_buf || hit_tsel || hit_dir ||
                        hit_flag || hit_stat || (|hit_tcon) || (|hit_per) || (|hit_cnt);
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !mapped;
  assign prdata       = prdata_q;

  // Channel state.
  assign pwm_mode  = (channel_control_reg_q[CTRL_MODE_LSB+2 +: 2] == CTRL_PWM_MODE);
  assign duty_prog = {duty_high_bits_reg_q,
                      channel_control_reg_q[CTRL_DLSB_LSB +: 2]};
  assign duty_lat  = {duty_buffer_reg_q, duty_lsb_latch_q};
  assign sel_valid = (timer_select_reg_q < 2'(NUM_TMR));
  // Select value three names no timer, so the channel simply stops advancing.
  assign reload    = sel_valid && tmr_stat[timer_select_reg_q].rollover;
  assign timebase  = sel_valid ? {tmr_stat[timer_select_reg_q].count,
                                  tmr_stat[timer_select_reg_q].low2} : 10'h3ff;
  assign q_tick    = !sleep_en && (q_phase_q == 2'(Q_CYCLES - 1));
  assign pin_o     = pwm_level;
  assign pin_oe    = pwm_mode && !pin_direction_bit_q;

  // Period timers, one group of registers each.
  genvar k;
  generate
    for (k = 0; k < NUM_TMR; k++) begin : g_tmr
      localparam logic [11:0] BASE = 12'(ADDR_TMR_BASE + TMR_STRIDE * 12'(k));

      assign hit_tcon[k] = (paddr == 12'(BASE + TMR_CON_OFS));
      assign hit_per[k]  = (paddr == 12'(BASE + TMR_PER_OFS));
      assign hit_cnt[k]  = (paddr == 12'(BASE + TMR_CNT_OFS));

      assign tmr_cfg[k].run       = timer_control_reg_q[k][TCON_RUN_BIT];
      assign tmr_cfg[k].prescale  = spwm_psc_t'(timer_control_reg_q[k][TCON_PSC_LSB +: 2]);
      assign tmr_cfg[k].postscale = timer_control_reg_q[k][TCON_POST_LSB +: 4];
      assign tmr_cfg[k].period    = period_limit_reg_q[k];
      assign flag_set[k]          = tmr_stat[k].flag_set;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          timer_control_reg_q[k] <= TCON_RST;
          period_limit_reg_q[k]  <= PER_RST;
        end else if (wr) begin
          if (hit_tcon[k]) begin
            timer_control_reg_q[k] <= pwdata[6:0];
          end
          if (hit_per[k]) begin
            period_limit_reg_q[k] <= pwdata[7:0];
          end
        end
      end

      spwm_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .q_tick  (q_tick),
        .q_phase (q_phase_q),
        .cfg     (tmr_cfg[k]),
        .stat    (tmr_stat[k])
      );
    end
  endgenerate

  // Instruction cycle phase; stalls in sleep so the time base freezes whole.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_phase_q <= 2'h0;
    end else if (!sleep_en) begin
      q_phase_q <= q_phase_q + 2'h1;
    end
  end

  // Channel control and duty registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_control_reg_q <= CTRL_RST;
      duty_high_bits_reg_q  <= DUTY_RST;
      timer_select_reg_q    <= TSEL_RST;
      pin_direction_bit_q   <= DIR_RST;
    end else if (wr) begin
      if (hit_ctrl) begin
        channel_control_reg_q <= pwdata[7:0];
      end
      if (hit_duty_hi) begin
        duty_high_bits_reg_q <= pwdata[7:0];
      end
      if (hit_tsel) begin
        timer_select_reg_q <= pwdata[1:0];
      end
      if (hit_dir) begin
        pin_direction_bit_q <= pwdata[0];
      end
    end
  end

  // Double buffer: both halves load on the same edge, so no mixed value is compared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_buffer_reg_q <= DUTY_RST;
      duty_lsb_latch_q  <= 2'h0;
    end else if (pwm_mode) begin
      if (reload) begin
        duty_buffer_reg_q <= duty_high_bits_reg_q;
        duty_lsb_latch_q  <= channel_control_reg_q[CTRL_DLSB_LSB +: 2];
      end
    end else if (wr && hit_duty_buf) begin
      duty_buffer_reg_q <= pwdata[7:0];
    end
  end

  // Match flags: a set in the same cycle as a clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_match_flag_q <= 3'h0;
    end else begin
      timer_match_flag_q <= (timer_match_flag_q &
                             ~((wr && hit_flag) ? pwdata[2:0] : 3'h0)) | flag_set;
    end
  end

  // Pad input synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Read mux.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_data[7:0] = channel_control_reg_q;
    end
    if (hit_duty_hi) begin
      rd_data[7:0] = duty_high_bits_reg_q;
    end
    if (hit_duty_buf) begin
      rd_data[7:0] = duty_buffer_reg_q;
    end
    if (hit_tsel) begin
      rd_data[1:0] = timer_select_reg_q;
    end
    if (hit_dir) begin
      rd_data[0] = pin_direction_bit_q;
    end
    if (hit_flag) begin
      rd_data[2:0] = timer_match_flag_q;
    end
    if (hit_stat) begin
      rd_data[STAT_PWM_BIT] = pwm_level;
      rd_data[STAT_OE_BIT]  = pin_oe;
      rd_data[STAT_PIN_BIT] = pin_sync_q;
    end
    for (int i = 0; i < NUM_TMR; i++) begin
      if (hit_tcon[i]) begin
        rd_data[6:0] = timer_control_reg_q[i];
      end
      if (hit_per[i]) begin
        rd_data[7:0] = period_limit_reg_q[i];
      end
      if (hit_cnt[i]) begin
        rd_data[7:0] = tmr_stat[i].count;
      end
    end
  end

  // Read data is taken in the setup cycle and held through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_data;
    end
  end

  // Output latch; high time follows from the time base stepping at the prescaled rate.
  spwm_out u_out (
    .pclk      (pclk),
    .presetn   (presetn),
    .pwm_mode  (pwm_mode),
    .advance   (!sleep_en),
    .reload    (reload),
    .duty_next (duty_prog),
    .duty_lat  (duty_lat),
    .timebase  (timebase),
    .pwm_q     (pwm_level)
  );

endmodule // spwm_top

`default_nettype wire

// ===== tb/spwm_properties.sv
// Purpose: Concurrent checks on the pin ports of the PWM channel, tracking its bus writes.
// Assumes: Shadow registers follow APB writes exactly as the slave takes them.
// Notes:   Timing checks wait for quiet periods, since a config write bends one period.
`default_nettype none

module spwm_checker
  import spwm_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Power and pin
  input wire logic        sleep_en,
  input wire logic        pin_i,
  input wire logic        pin_o,
  input wire logic        pin_oe
);
  logic [7:0]       ctrl_q, dhi_q, tcon_q, per_q;
  logic [1:0]       tsel_q, quiet_q;
  logic             dir_q, prev_q;
  logic [31:0]      pcnt_q, hcnt_q;
  wire logic        wr   = psel & penable & pwrite;
  wire logic        rise = pin_o & ~prev_q;
  wire logic        fall = ~pin_o & prev_q;
  wire logic        pwm  = ctrl_q[3:2] == CTRL_PWM_MODE;
  wire logic        t0   = tsel_q == 2'h0;
  wire logic [9:0]  duty = {dhi_q, ctrl_q[5:4]};
  wire logic [31:0] psc  = tcon_q[1] ? 32'h10 : (tcon_q[0] ? 32'h4 : 32'h1);
  wire logic [31:0] plen = ({24'h0, per_q} + 32'h1) * 32'h4 * psc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= CTRL_RST;
      dhi_q   <= DUTY_RST;
      tcon_q  <= 8'h00;
      per_q   <= PER_RST;
      tsel_q  <= TSEL_RST;
      dir_q   <= DIR_RST;
      prev_q  <= 1'b0;
      pcnt_q  <= 32'h0;
      hcnt_q  <= 32'h0;
      quiet_q <= 2'h0;
    end else begin
      if (wr && paddr == ADDR_CTRL) ctrl_q <= pwdata[7:0];
      if (wr && paddr == ADDR_DUTY_HI) dhi_q <= pwdata[7:0];
      if (wr && paddr == ADDR_TSEL) tsel_q <= pwdata[1:0];
      if (wr && paddr == ADDR_DIR) dir_q <= pwdata[0];
      if (wr && paddr == ADDR_TMR_BASE + TMR_CON_OFS) tcon_q <= pwdata[7:0];
      if (wr && paddr == ADDR_TMR_BASE + TMR_PER_OFS) per_q <= pwdata[7:0];
      prev_q <= pin_o;
      pcnt_q <= rise ? 32'h1 : pcnt_q + 32'h1;
      hcnt_q <= pin_o ? hcnt_q + 32'h1 : 32'h0;
      if (wr || sleep_en) quiet_q <= 2'h0;
      else if (rise && quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_drive_enable: assert property (pin_oe == (pwm && !dir_q))
    else $error("pin drive enable does not follow mode and direction");
  chk_release_zero: assert property (ctrl_q == CTRL_RST |-> !pin_oe)
    else $error("channel keeps the pin after its control is cleared");
  chk_reset_input: assert property (disable iff (1'b0) !presetn |-> !pin_oe && !pin_o)
    else $error("pin is driven during reset");
  chk_sleep_hold: assert property (sleep_en |=> $stable(pin_o))
    else $error("pin level moved during sleep");
  chk_idle_low: assert property ((!pwm && !sleep_en) [*2] |-> !pin_o)
    else $error("pin high outside the modulation mode");
  chk_period_len: assert property (rise && quiet_q >= 2'h2 && t0 |-> pcnt_q == plen)
    else $error("period length differs from the period limit");
  chk_high_time: assert property (fall && quiet_q != 2'h0 && t0 |-> hcnt_q == {22'h0, duty} * psc)
    else $error("high time differs from the duty value");
  chk_zero_duty: assert property (rise |-> $past(duty, 2) != 10'h000)
    else $error("pin set at reload with zero duty");

  cover property (rise && quiet_q >= 2'h2 && t0);
  cover property (fall && quiet_q != 2'h0);
  cover property (sleep_en ##1 !sleep_en);
endmodule // spwm_checker

bind spwm_top spwm_checker spwm_checker_i (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .sleep_en, .pin_i, .pin_o, .pin_oe
);

`default_nettype wire

// ===== tb/spwm_load.sv
// Purpose: Load on the PWM pin that measures the last period and high time.
// Assumes: The pin has no pull, so a released pin shows a changing level.
// Notes:   Lengths are counted in pclk cycles between edges of the pin level.
`default_nettype none

module spwm_load (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Pin
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  output logic             pin_i,
  // Measurements
  output logic      [31:0] per_len,
  output logic      [31:0] hi_len
);
  logic        lvl_q, prev_q;
  logic [31:0] cnt_q, hcnt_q;

  assign pin_i = pin_oe ? pin_o : ~lvl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q   <= 1'b0;
      prev_q  <= 1'b0;
      cnt_q   <= 32'h0;
      hcnt_q  <= 32'h0;
      per_len <= 32'h0;
      hi_len  <= 32'h0;
    end else begin
      lvl_q  <= pin_i;
      prev_q <= pin_i;
      cnt_q  <= (pin_i && !prev_q) ? 32'h1 : cnt_q + 32'h1;
      hcnt_q <= pin_i ? hcnt_q + 32'h1 : 32'h0;
      if (pin_i && !prev_q) per_len <= cnt_q;
      if (!pin_i && prev_q) hi_len <= hcnt_q;
    end
  end
endmodule // spwm_load

`default_nettype wire

// ===== tb/spwm_top_tb.sv
// Purpose: Self-checking bench of the PWM channel over APB.
// Assumes: One load model on the pin; a single clock domain.
// Notes:   Period checks wait three periods so that a config change settles first.
`default_nettype none

module spwm_top_tb
  import spwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] T0 = ADDR_TMR_BASE;
  localparam logic [11:0] T1 = ADDR_TMR_BASE + TMR_STRIDE;

  logic             pclk, presetn, psel, penable, pwrite, sleep_en, err_s, lvl;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, rd, cnt;
  wire logic [31:0] prdata, per_len, hi_len;
  wire logic        pready, pslverr, pin_i, pin_o, pin_oe;
  int               error_cnt = 0;
  int               total_checks = 0;
  int               n;

  spwm_top spwm_top_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .sleep_en, .pin_i, .pin_o, .pin_oe
  );
  spwm_load spwm_load_i (.pclk, .presetn, .pin_o, .pin_oe, .pin_i, .per_len, .hi_len);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timeout();
    error_cnt++;
    stop_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // The slave holds pready high and never stretches the access phase; pready is still polled.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) timeout();
    rd      = prdata;
    err_s   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic meas(input int per, input int hi);
    cyc(3 * per + 8);
    chk(per_len, per);
    chk(hi_len, hi);
  endtask

  task automatic hold(input logic [31:0] exp);
    cyc(40);
    for (int i = 0; i < 4; i++) begin
      cyc(5);
      chk(pin_o, exp);
    end
  endtask

  task automatic wait_rise();
    int   k;
    logic p;
    for (k = 0; k < 2000; k++) begin
      p = pin_o;
      @(negedge pclk);
      if (p === 1'b0 && pin_o === 1'b1) break;
    end
    if (k == 2000) timeout();
  endtask

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    sleep_en = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    cyc(10);
    presetn <= 1'b1;
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_DUTY_BUF, 32'h0);
    rdc(ADDR_TSEL, 32'h0);
    rdc(ADDR_DIR, 32'h1);
    rdc(T0 + TMR_CON_OFS, 32'h0);
    rdc(T0 + TMR_PER_OFS, 32'hff);
    chk(pin_oe, 32'h0);
    apb(12'h01c, 1'b0, 32'h0);
    chk({31'h0, err_s}, 32'h1);
    chk(rd, 32'h0);
    wr(ADDR_TSEL, 32'h0);
    wr(T0 + TMR_PER_OFS, 32'h3);
    wr(ADDR_CTRL, 32'h1c);
    wr(ADDR_DUTY_HI, 32'h1);
    wr(ADDR_FLAG, 32'h7);
    wr(T0 + TMR_CON_OFS, 32'h4);
    for (n = 0; n < 50; n++) begin
      apb(ADDR_FLAG, 1'b0, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    if (n == 50) timeout();
    wr(ADDR_DIR, 32'h0);
    chk(pin_oe, 32'h1);
    chk(pin_i, pin_o);
    meas(16, 5);
    // Prescale 1:4 and 1:16 must scale period and high time; the non-zero postscale written with it must not.
    for (int i = 1; i < 4; i++) begin
      wr(T0 + TMR_CON_OFS, 32'h4 | i | (i << 3));
      meas(16 * (i == 1 ? 4 : 16), 5 * (i == 1 ? 4 : 16));
    end
    wr(T0 + TMR_CON_OFS, 32'h4);
    wait_rise();
    wr(ADDR_DUTY_HI, 32'h2);
    rdc(ADDR_DUTY_BUF, 32'h1);
    wr(ADDR_DUTY_BUF, 32'h55);
    rdc(ADDR_DUTY_BUF, 32'h1);
    meas(16, 9);
    rdc(ADDR_DUTY_BUF, 32'h2);
    wr(ADDR_DUTY_HI, 32'hff);
    wr(ADDR_CTRL, 32'h3c);
    hold(32'h1);
    rdc(ADDR_STAT, 32'h7);
    wr(ADDR_DUTY_HI, 32'h0);
    wr(ADDR_CTRL, 32'h0c);
    hold(32'h0);
    wr(ADDR_DUTY_HI, 32'h1);
    wr(ADDR_CTRL, 32'h1c);
    wr(T1 + TMR_PER_OFS, 32'h1);
    wr(T1 + TMR_CON_OFS, 32'h4);
    wr(ADDR_TSEL, 32'h1);
    meas(8, 5);
    wr(T1 + TMR_PER_OFS, 32'hff);
    wr(ADDR_DUTY_HI, 32'hff);
    wr(ADDR_CTRL, 32'h2c);
    meas(1024, 1022);
    sleep_en <= 1'b1;
    cyc(2);
    apb(T1 + TMR_CNT_OFS, 1'b0, 32'h0);
    cnt = rd;
    lvl = pin_o;
    cyc(30);
    rdc(T1 + TMR_CNT_OFS, cnt);
    chk(pin_o, lvl);
    cyc(1);
    sleep_en <= 1'b0;
    cyc(30);
    apb(T1 + TMR_CNT_OFS, 1'b0, 32'h0);
    chk({31'h0, rd !== cnt}, 32'h1);
    // Select value three names no timer, so the pin must keep its level.
    wr(ADDR_TSEL, 32'h3);
    cyc(2);
    lvl = pin_o;
    hold(lvl);
    wr(ADDR_CTRL, 32'h0);
    chk(pin_oe, 32'h0);
    wr(ADDR_CTRL, 32'h1c);
    chk(pin_oe, 32'h1);
    cyc(1);
    presetn <= 1'b0;
    cyc(2);
    chk(pin_oe, 32'h0);
    chk(pin_o, 32'h0);
    presetn <= 1'b1;
    rdc(ADDR_DIR, 32'h1);
    rdc(ADDR_CTRL, 32'h0);
    stop_test();
  end

  initial begin
    cyc(60000);
    timeout();
  end
endmodule // spwm_top_tb

`default_nettype wire
